// ==== logic/calm_pkg.sv ====
package calm_pkg;

  // channel order of the alarm vector
  localparam int CALM_NCH      = 8;
  localparam int CH_FAN        = 0;
  localparam int CH_TEMP       = 1;
  localparam int CH_R33        = 2;
  localparam int CH_R5         = 3;
  localparam int CH_R12        = 4;
  localparam int CH_RN12       = 5;
  localparam int CH_STBY       = 6;
  localparam int CH_REFCLK     = 7;
  localparam int CALM_NFAN     = 4;

  // sensor word widths (fan in rpm, temp in deg c, rails in millivolts, signed)
  localparam int CALM_VW       = 16;

  // register byte offsets
  localparam logic [5:0] REG_STATUS   = 6'h00; // latched alarms, read only
  localparam logic [5:0] REG_CLEAR    = 6'h04; // write one to clear, write only
  localparam logic [5:0] REG_ENABLE   = 6'h08; // alarm unmask
  localparam logic [5:0] REG_OCCUR    = 6'h0c; // latch and unmask, read only
  localparam logic [5:0] REG_LIVE     = 6'h10; // live limit-crossed, read only
  localparam logic [5:0] REG_CTRL     = 6'h14; // bit0 chassis reset strobe
  localparam logic [5:0] REG_FAN_MIN  = 6'h18;
  localparam logic [5:0] REG_TEMP_MAX = 6'h1c;
  localparam logic [5:0] REG_RAIL_LIM = 6'h20; // 0x20..0x30: {hi,lo} per rail
  localparam int         CALM_NRAIL   = 5;
  localparam logic [5:0] REG_RAIL_END = 6'h34;
  localparam logic [5:0] REG_PWR      = 6'h38; // bit0 main switch state, read only

  // factory thresholds
  localparam logic [15:0] FAN_MIN_SMALL = 16'd900;
  localparam logic [15:0] FAN_MIN_STD   = 16'd1200;
  localparam logic [15:0] TEMP_MAX_DEF  = 16'd70;
  localparam logic [15:0] RAIL_HI_DEF [CALM_NRAIL] =
    '{16'd3630, 16'd5250, 16'd12600, 16'hd378, 16'd5250};
  localparam logic [15:0] RAIL_LO_DEF [CALM_NRAIL] =
    '{16'd2970, 16'd4750, 16'd11400, 16'hcec8, 16'd4750};

  // led flash half period
  localparam int FLASH_HALF_MS = 250;
  localparam int CLK_KHZ       = 200000;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_KHZ;

  // push button debounce, in microseconds
  localparam int BTN_DEB_US  = 10000;
  localparam int BTN_DEB_CYC = BTN_DEB_US * (CLK_KHZ / 1000);

  typedef struct packed {
    logic [CALM_NFAN-1:0][CALM_VW-1:0]  fan_rpm;
    logic [CALM_VW-1:0]                 temp_c;
    logic [CALM_NRAIL-1:0][CALM_VW-1:0] rail_mv;
    logic                               refclk_changed;
  } calm_sense_t;

  typedef struct packed {
    logic fan;
    logic temp;
    logic power;
  } calm_led_t;

  typedef struct packed {
    logic main_on;
    logic standby_on;
    logic fan_supply_on;
  } calm_rails_t;

  typedef enum logic [1:0] {
    PWR_OFF,
    PWR_ON
  } calm_pwr_e_t;

endpackage : calm_pkg

// ==== logic/calm_alarm.sv ====
`timescale 1ns/100ps
`default_nettype none

module calm_alarm
  import calm_pkg::*;
#(
  parameter int FLASH_HALF = FLASH_HALF_CYC,
  parameter int DEB_CYC    = BTN_DEB_CYC
)(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  // chassis variant strap, level
  input  wire logic                small_chassis,
  // sensors, from outside the clock domain
  input  wire calm_sense_t         sense,
  // power controls
  input  wire logic                mains_present,
  input  wire logic                power_button,
  input  wire logic                inhibit,
  // wishbone classic slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [5:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  output logic                     wb_err_o,
  // indicators, rails, interrupt
  output logic                     irq,
  output calm_led_t                led,
  output calm_rails_t              rails
);

  typedef struct packed {
    calm_sense_t                        s1;
    calm_sense_t                        s2;
    logic [2:0]                         p1;
    logic [2:0]                         p2;
    logic [15:0]                        fan_min;
    logic [15:0]                        temp_max;
    logic [CALM_NRAIL-1:0][15:0]        rail_hi;
    logic [CALM_NRAIL-1:0][15:0]        rail_lo;
    logic [CALM_NCH-1:0]                latch;
    logic [CALM_NCH-1:0]                enable;
    logic [31:0]                        flash_cnt;
    logic                               flash;
    logic [31:0]                        deb_cnt;
    logic                               btn_stable;
    logic                               main_sw;
    logic                               ack;
    logic                               err;
    logic [31:0]                        rdata;
    logic                               init;
    logic [1:0]                         warm;     // sync pipe filled, readings trusted
    calm_led_t                          led;
    calm_rails_t                        rails;
  } calm_state_t;

  calm_state_t st;
  calm_state_t next_st;

  logic [CALM_NCH-1:0] crossed;
  logic                req;
  logic                rail_hit;
  logic [3:0]          rail_idx;

  // byte lane merge used by every threshold register
  // only lanes 0 and 1 reach a 16-bit threshold; a rail word calls it twice,
  // once per half, so one helper serves both limits
  function automatic logic [15:0] calm_merge(input logic [15:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  sel);
    calm_merge = old;
    if (sel[0]) calm_merge[7:0] = d[7:0];
    if (sel[1]) calm_merge[15:8] = d[15:8];
  endfunction : calm_merge

  // outside-window test on signed rail words
  // signed so the negative rail window needs no offset; a value sitting
  // exactly on a limit still counts as inside
  function automatic logic calm_outside(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    calm_outside = ($signed(v) > $signed(hi)) || ($signed(v) < $signed(lo));
  endfunction : calm_outside

  // limit comparisons on the synchronised sensor values
  // fans use an unsigned compare: a stalled fan reads zero, below any minimum
  // any single slow fan raises the shared fan channel
  always_comb
  begin
    crossed = '0;
    for (int f = 0; f < CALM_NFAN; f++)
    begin
      if (st.s2.fan_rpm[f] < st.fan_min)
      begin
        crossed[CH_FAN] = 1'b1;
      end
    end
    crossed[CH_TEMP] = st.s2.temp_c > st.temp_max;
    for (int r = 0; r < CALM_NRAIL; r++)
    begin
      crossed[CH_R33 + r] = calm_outside(st.s2.rail_mv[r], st.rail_lo[r],
                                         st.rail_hi[r]);
    end
    crossed[CH_REFCLK] = st.s2.refclk_changed;
    // the sync pipe still holds reset zeros for two edges; zero readings
    // against freshly loaded thresholds would latch the fan and rail channels at power-up
    if (!(&st.warm))
    begin
      crossed = '0;
    end
  end

  // register map, one 32-bit word per offset
  //   status   latched alarms, read only
  //   clear    write one per channel to drop its latch, write only
  //   enable   per-channel unmask, read and write
  //   occur    latch and unmask, read only
  //   live     present limit-crossed state, read only
  //   ctrl     bit 0 written high runs a chassis reset
  //   fan_min  minimum fan speed in rpm
  //   temp_max maximum temperature in degrees
  //   rails    one word per rail, upper limit high half, lower limit low half
  //   pwr      bit 0 shows the main switch state
  // channel bits: fan, temperature, five rails, reference clock change
  // any other offset outside the rail words 0x20..0x33, the word after the last rail included, answers with err
  // so a stray pointer in software is seen at once instead of aliasing
  // writes to read-only words are acknowledged and dropped
  // only the low byte lane carries channel bits; thresholds use two lanes
  // a new request is taken only once the previous answer has gone
  assign req      = wb_cyc_i && wb_stb_i && !st.ack && !st.err;
  // rail index is the word offset from the first rail word
  assign rail_hit = (wb_adr_i >= REG_RAIL_LIM) && (wb_adr_i < REG_RAIL_END);
  assign rail_idx = 4'((wb_adr_i - REG_RAIL_LIM) >> 2);

  // next state
  // every piece of state is computed here and registered once below, so a
  // low clock enable holds sensors, counters, latches and bus answer alike
  // sensor words and power pins pass two flops before anything compares them;
  // a multi-bit word caught mid-change can be torn for one cycle, a limit for
  // values hovering on a threshold, traded for having no handshake to sensors
  // bus answer, read data and all panel and rail outputs come from flops, so
  // the drivers outside never see a comparator glitch
  always_comb
  begin
    logic restore;
    logic clr_req;
    logic [CALM_NCH-1:0] clr;
    restore = 1'b0;
    clr_req = 1'b0;
    clr     = '0;
    next_st = st;
    next_st.s1 = sense;
    next_st.s2 = st.s1;
    next_st.p1 = {mains_present, power_button, inhibit};
    next_st.p2 = st.p1;
    next_st.ack = 1'b0;
    next_st.err = 1'b0;
    next_st.init = 1'b1;
    // fills one stage per edge, full once the sync pipe holds real readings
    next_st.warm = {st.warm[0], 1'b1};

    // free-running flash divider
    // it never stops, so every flashing indicator shares one phase and a
    // panel with several alarms blinks in step
    if (st.flash_cnt >= 32'(FLASH_HALF - 1))
    begin
      next_st.flash_cnt = '0;
      next_st.flash = !st.flash;
    end
    else
      next_st.flash_cnt = st.flash_cnt + 32'd1;

    // register access, answered one cycle after the request
    // read data is built from the state seen at the taking edge; a write in
    // the same access lands at that edge too
    if (req)
    begin
      next_st.ack = 1'b1;
      next_st.rdata = '0;
      unique case (1'b1)
        wb_adr_i == REG_STATUS:   next_st.rdata[CALM_NCH-1:0] = st.latch;
        wb_adr_i == REG_CLEAR:    ;
        wb_adr_i == REG_ENABLE:   next_st.rdata[CALM_NCH-1:0] = st.enable;
        wb_adr_i == REG_OCCUR:    next_st.rdata[CALM_NCH-1:0] = st.latch & st.enable;
        wb_adr_i == REG_LIVE:     next_st.rdata[CALM_NCH-1:0] = crossed;
        wb_adr_i == REG_CTRL:     ;
        wb_adr_i == REG_FAN_MIN:  next_st.rdata[15:0] = st.fan_min;
        wb_adr_i == REG_TEMP_MAX: next_st.rdata[15:0] = st.temp_max;
        rail_hit:                 next_st.rdata = {st.rail_hi[rail_idx], st.rail_lo[rail_idx]};
        wb_adr_i == REG_PWR:      next_st.rdata[0] = st.main_sw;
        // unmapped: refuse with err and zero the read data, all other state untouched
        default:
        begin
          next_st.ack = 1'b0;
          next_st.err = 1'b1;
        end
      endcase
      if (wb_we_i)
      begin
        // clear is write-one; zero bits leave their latch alone
        if (wb_adr_i == REG_CLEAR && wb_sel_i[0])
        begin
          clr = wb_dat_i[CALM_NCH-1:0];
        end
        // unmask only gates the interrupt and occur word, never the latch
        if (wb_adr_i == REG_ENABLE && wb_sel_i[0])
        begin
          next_st.enable = wb_dat_i[CALM_NCH-1:0];
        end
        // chassis reset is a strobe, nothing of it is stored
        if (wb_adr_i == REG_CTRL && wb_sel_i[0])
        begin
          clr_req = wb_dat_i[0];
        end
        // thresholds merge per byte lane so a partial write keeps the other half
        if (wb_adr_i == REG_FAN_MIN)
        begin
          next_st.fan_min = calm_merge(st.fan_min, wb_dat_i, wb_sel_i);
        end
        if (wb_adr_i == REG_TEMP_MAX)
        begin
          next_st.temp_max = calm_merge(st.temp_max, wb_dat_i, wb_sel_i);
        end
        // rail word: low half is the lower limit, high half the upper
        if (rail_hit)
        begin
          next_st.rail_lo[rail_idx] = calm_merge(st.rail_lo[rail_idx], wb_dat_i, wb_sel_i);
          next_st.rail_hi[rail_idx] = calm_merge(st.rail_hi[rail_idx], wb_dat_i >> 16,
                                                 wb_sel_i >> 2);
        end
      end
    end

    // software chassis reset clears latches and restores thresholds
    // the first edge after reset and a software chassis reset share one path,
    // so both always load the same defaults; the strap is read at that moment
    restore = !st.init || clr_req;
    if (clr_req) clr = '1;
    if (restore)
    begin
      next_st.fan_min  = small_chassis ? FAN_MIN_SMALL : FAN_MIN_STD;
      next_st.temp_max = TEMP_MAX_DEF;
      for (int r = 0; r < CALM_NRAIL; r++)
      begin
        next_st.rail_hi[r] = RAIL_HI_DEF[r];
        next_st.rail_lo[r] = RAIL_LO_DEF[r];
      end
    end

    // set wins over clear, so a live condition re-latches at once
    // software that clears while a fault persists reads the bit back set,
    // which is the honest answer; a lowered threshold never clears a latch
    next_st.latch = (st.latch & ~clr) | crossed;

    // button press toggles main rails; inhibit forces them off
    // the button must hold a new level for the whole debounce count before it
    // is believed; only the press edge toggles, release does nothing
    // losing mains drops the switch too, so rails come back off with mains
    if (st.p2[1] != st.btn_stable)
    begin
      if (st.deb_cnt >= 32'(DEB_CYC - 1))
      begin
        next_st.btn_stable = st.p2[1];
        next_st.deb_cnt = '0;
        if (st.p2[1]) next_st.main_sw = !st.main_sw;
      end
      else
        next_st.deb_cnt = st.deb_cnt + 32'd1;
    end
    else
      next_st.deb_cnt = '0;
    if (!st.p2[2]) next_st.main_sw = 1'b0;

    // standby and fan supply follow mains alone; button and inhibit only
    // reach the switchable main rails
    next_st.rails.standby_on    = st.p2[2];
    next_st.rails.fan_supply_on = st.p2[2];
    next_st.rails.main_on       = st.p2[2] && st.main_sw && !st.p2[0];

    // panel: flash on crossed, else fan/power lit and temperature dark
    // indicators follow the live condition, not the latch, so a recovered
    // channel goes steady while its latch still reports the past alarm
    next_st.led.fan   = crossed[CH_FAN] ? st.flash : 1'b1;
    next_st.led.temp  = crossed[CH_TEMP] ? st.flash : 1'b0;
    next_st.led.power = |crossed[CH_STBY:CH_R33] ? st.flash : 1'b1;
  end

  // registered state; init low after reset triggers the default load
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      st <= '0;
    else if (clk_en)
      st <= next_st;
  end

  // outputs
  // the interrupt is a level from registered latch and unmask; it stays high
  // until software clears the latch or masks the channel
  assign wb_ack_o = st.ack;
  assign wb_err_o = st.err;
  assign wb_dat_o = st.rdata;
  assign irq      = |(st.latch & st.enable);
  assign led      = st.led;
  assign rails    = st.rails;

endmodule : calm_alarm

`default_nettype wire

// ==== dv/calm_alarm_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module calm_alarm_assertions
  import calm_pkg::*;
#(
  parameter int FLASH_HALF = 4,
  parameter int DEB_CYC    = 4
)(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  // strap, sensors, power controls
  input wire logic        small_chassis,
  input wire calm_sense_t sense,
  input wire logic        mains_present,
  input wire logic        power_button,
  input wire logic        inhibit,
  // register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  // indicators, rails, interrupt
  input wire logic        irq,
  input wire calm_led_t   led,
  input wire calm_rails_t rails
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a request counts only once the previous answer has gone
  sequence take_s;
    wb_cyc_i && wb_stb_i && clk_en && !wb_ack_o && !wb_err_o;
  endsequence
  sequence unmask_off_s;
    take_s ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == REG_ENABLE && wb_dat_i[7:0] == 8'h00);
  endsequence
  // bus answers
  one_answer_a: assert property (take_s |=> wb_ack_o != wb_err_o)
    else $error("request without a single answer");
  unmapped_err_a: assert property (take_s ##0 (wb_adr_i > 6'h38) |=> wb_err_o)
    else $error("unmapped access not refused");
  mapped_ack_a: assert property (take_s ##0 (wb_adr_i <= 6'h38 && wb_adr_i[1:0] == 2'b00
                                 && wb_adr_i != REG_RAIL_END) |=> wb_ack_o)
    else $error("mapped access not acknowledged");
  answer_pulse_a: assert property (wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
    else $error("answer longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  // masking hides the interrupt within two cycles
  mask_irq_a: assert property (unmask_off_s |=> ##[0:1] !irq)
    else $error("irq still high with all masked");
  // rails against mains and inhibit, three sync and register stages
  standby_on_a: assert property ((mains_present && clk_en)[*4] |=> rails.standby_on && rails.fan_supply_on)
    else $error("standby rails off with mains");
  standby_off_a: assert property ((!mains_present && clk_en)[*4] |=> rails == 3'b000)
    else $error("rails on without mains");
  inhibit_off_a: assert property ((inhibit && clk_en)[*4] |=> !rails.main_on)
    else $error("main rails on while inhibited");
endmodule : calm_alarm_assertions
bind calm_alarm calm_alarm_assertions #(.FLASH_HALF(FLASH_HALF), .DEB_CYC(DEB_CYC)) u_chk (.*);
`default_nettype wire

// ==== dv/calm_sensors.sv ====
`timescale 1ns/100ps
`default_nettype none
module calm_sensors
  import calm_pkg::*;
(
  // commanded faults, one bit per channel
  input  wire logic [7:0] fault,
  // readings toward the device
  output calm_sense_t     sense
);
  localparam logic [15:0] NOM [CALM_NRAIL] = '{16'd3300, 16'd5000, 16'd12000, 16'hd120, 16'd5000};
  // nominal readings; a fault pulls one fan down or a rail to zero volts
  always_comb
  begin
    sense.fan_rpm = {CALM_NFAN{16'd3000}};
    if (fault[CH_FAN])
      sense.fan_rpm[2] = 16'd100;
    sense.temp_c = fault[CH_TEMP] ? 16'd80 : 16'd40;
    for (int i = 0; i < CALM_NRAIL; i++)
      sense.rail_mv[i] = fault[CH_R33 + i] ? 16'h0000 : NOM[i];
    sense.refclk_changed = fault[CH_REFCLK];
  end
endmodule : calm_sensors
`default_nettype wire

// ==== dv/tb_calm_alarm.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module tb_calm_alarm
  import calm_pkg::*;
;
  // bench drive and design outputs
  logic        ref_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        small_chassis = 1'b0, mains_present = 1'b0, power_button = 1'b0, inhibit = 1'b0;
  logic        wb_ack_o, wb_err_o, irq, err_seen;
  logic [5:0]  adr = 6'h00;
  logic [7:0]  fault = 8'h00;
  logic [31:0] dat = 32'h0, wb_dat_o, rdat;
  calm_sense_t sense;
  calm_led_t   led;
  calm_rails_t rails;
  int          bad_count = 0, num_checks = 0, n;
  always #2.5 ref_clk = ~ref_clk;
  // short flash and debounce counts keep the run brief
  calm_sensors u_sense (.fault(fault), .sense(sense));
  calm_alarm #(.FLASH_HALF(4), .DEB_CYC(4)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .clk_en(1'b1), .small_chassis(small_chassis), .sense(sense), .mains_present(mains_present),
    .power_button(power_button), .inhibit(inhibit), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .irq(irq), .led(led), .rails(rails));
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // answer sampled at the rising edge, before that edge's updates land
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    i = 0;
    do
    begin
      @(posedge ref_clk);
      i++;
    end
    while (i < 20 && wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
    begin
      bad_count++;
      conclude();
    end
    rdat = wb_dat_o;
    err_seen = wb_err_o;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CK(rdat, e)
  endtask : rd
  task automatic fin(input string s);
    $display("test %s finished", s);
  endtask : fin
  // main sequence; sensor changes get eight cycles to pass the sync stages
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    mains_present <= 1'b1;
    rd(REG_FAN_MIN, 32'd1200);
    rd(REG_TEMP_MAX, 32'd70);
    rd(REG_RAIL_LIM + 6'h0c, 32'hd378cec8);
    wb(1'b1, REG_FAN_MIN, 32'd500);
    rd(REG_FAN_MIN, 32'd500);
    wb(1'b1, REG_ENABLE, 32'hff);
    rd(REG_STATUS, 32'h0);
    @(negedge ref_clk);
    `CK(led, 3'b101)
    `CK(rails.standby_on && rails.fan_supply_on, 1'b1)
    fin("defaults");
    @(posedge ref_clk) fault <= 8'hff;
    repeat (8) @(posedge ref_clk);
    rd(REG_LIVE, 32'hff);
    rd(REG_STATUS, 32'hff);
    rd(REG_OCCUR, 32'hff);
    n = 0;
    repeat (24)
    begin
      @(negedge ref_clk);
      n += led.fan + led.temp + led.power;
    end
    `CK(n, 36)
    `CK(irq, 1'b1)
    fin("alarms");
    @(posedge ref_clk) fault <= 8'h00;
    repeat (8) @(posedge ref_clk);
    rd(REG_LIVE, 32'h0);
    rd(REG_STATUS, 32'hff);
    @(negedge ref_clk);
    `CK(led, 3'b101)
    wb(1'b1, REG_ENABLE, 32'h0);
    rd(REG_OCCUR, 32'h0);
    rd(REG_STATUS, 32'hff);
    `CK(irq, 1'b0)
    fin("recover and mask");
    wb(1'b1, REG_ENABLE, 32'hff);
    @(posedge ref_clk) fault <= 8'h02;
    repeat (8) @(posedge ref_clk);
    wb(1'b1, REG_CLEAR, 32'hff);
    rd(REG_STATUS, 32'h02);
    @(posedge ref_clk) fault <= 8'h00;
    repeat (8) @(posedge ref_clk);
    wb(1'b1, REG_CLEAR, 32'h02);
    rd(REG_STATUS, 32'h0);
    `CK(irq, 1'b0)
    small_chassis <= 1'b1;
    wb(1'b1, REG_CTRL, 32'h1);
    rd(REG_FAN_MIN, 32'd900);
    wb(1'b0, 6'h3c, 32'h0);
    `CK(err_seen, 1'b1)
    fin("clear and reset");
    power_button <= 1'b1;
    repeat (12) @(posedge ref_clk);
    power_button <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd(REG_PWR, 32'h1);
    inhibit <= 1'b1;
    repeat (8) @(negedge ref_clk);
    `CK(rails, 3'b011)
    @(posedge ref_clk) mains_present <= 1'b0;
    repeat (8) @(negedge ref_clk);
    `CK(rails, 3'b000)
    fin("power");
    conclude();
  end
endmodule : tb_calm_alarm
`default_nettype wire
